/* File: shared/eoc_link_pkg.sv */
// shared constants for the light-sensor two-wire link and its host controller
package eoc_link_pkg;
	// link timing: clock rate and two-wire bit rate, one bit is four quarters
	localparam int CLK_MHZ = 100;
	localparam int SCL_KHZ = 100;
	localparam int QUARTER_CYCLES = (CLK_MHZ * 1000) / (4 * SCL_KHZ);
	// sensor register pointers
	localparam logic [7:0] PTR_RESULT = 8'h00;
	localparam logic [7:0] PTR_CONFIG = 8'h01;
	localparam logic [7:0] PTR_LOWLIM = 8'h02;
	localparam logic [7:0] PTR_HIGHLIM = 8'h03;
	localparam logic [7:0] PTR_MFR_ID = 8'h7e;
	localparam logic [7:0] PTR_DEV_ID = 8'h7f;
	// configuration field positions
	localparam int CFG_MODE_LSB = 9;
	localparam int CFG_OVF = 8;
	localparam int CFG_CRF = 7;
	localparam int CFG_FH = 6;
	localparam int CFG_FL = 5;
	localparam int CFG_LATCH = 4;
	localparam int CFG_SENSE = 3;
	localparam int CFG_FC_LSB = 0;
	localparam int LIM_EOC_LSB = 14;
	localparam logic [1:0] EOC_CODE = 2'b11;
	localparam logic [1:0] MODE_SHUTDOWN = 2'b00;
	// sensor reset values
	localparam logic [15:0] CFG_RESET = 16'h0000;
	localparam logic [15:0] LOWLIM_RESET = 16'h0000;
	localparam logic [15:0] HIGHLIM_RESET = 16'hffff;
	// host controller register offsets and fields
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_WDATA = 4'h4;
	localparam logic [3:0] REG_STATUS = 4'h8;
	localparam logic [3:0] REG_RDATA = 4'hc;
	localparam int CTRL_GO = 0;
	localparam int CTRL_READ = 1;
	localparam int CTRL_PTR_LSB = 8;
	localparam int STAT_BUSY = 0;
	localparam int STAT_NACK = 1;
	localparam int STAT_IRQ = 2;
	localparam logic [1:0] AXI_OKAY = 2'b00;
	localparam logic [1:0] AXI_SLVERR = 2'b10;
endpackage

/* File: shared/eoc_link_if.sv */
// two-wire link between host controller and sensor, with open-drain resolution
`timescale 1ns/10ps
interface eoc_link_if;
	logic scl;
	logic hostSdaOut;
	logic hostSdaOe;
	logic devSdaOut;
	logic devSdaOe;
	logic devIrqOut;
	logic devIrqOe;
	logic sda;
	logic irqLine;
	// pulled high unless some enabled driver pulls low
	assign sda = ~((hostSdaOe & ~hostSdaOut) | (devSdaOe & ~devSdaOut));
	assign irqLine = ~(devIrqOe & ~devIrqOut);
	modport host (output scl, output hostSdaOut, output hostSdaOe, input sda, input irqLine);
	modport dev (input scl, output devSdaOut, output devSdaOe, input sda,
		output devIrqOut, output devIrqOe);
endinterface

/* File: core/eoc_sensor_dev.sv */
// sensor end: two-wire register slave with end-of-conversion interrupt reporting
`timescale 1ns/10ps
module eoc_sensor_dev import eoc_link_pkg::*; #(
	parameter logic [6:0] SLAVE_ADDR = 7'h2a,
	parameter logic [15:0] MFR_ID = 16'h1234, // arbitrary value
	parameter logic [15:0] DEV_ID = 16'h5678 // arbitrary value
) (
	// system
	input wire logic clk,
	input wire logic sys_rst,
	// two-wire link
	eoc_link_if.dev link,
	// conversion engine side
	input wire logic convDone,
	input wire logic [15:0] convResult,
	input wire logic alertWon,
	output logic [1:0] opMode,
	output logic [15:0] resultWord
);
	typedef enum logic [2:0] {
		D_IDLE = 3'b000,
		D_RX = 3'b001,
		D_ACK = 3'b010,
		D_TX = 3'b011,
		D_RACK = 3'b100
	} phase_type;

	typedef struct packed {
		phase_type phase;
		logic sclPrev;
		logic sdaPrev;
		logic [3:0] bitCnt;
		logic [1:0] byteIdx;
		logic rw;
		logic [7:0] shift;
		logic [7:0] ptr;
		logic [7:0] hiByte;
		logic [15:0] txWord;
		logic sdaDrive;
		logic [15:0] cfg;
		logic crf;
		logic flagHi;
		logic flagLo;
		logic irqActive;
		logic irqDrive;
		logic [15:0] lowLim;
		logic [15:0] highLim;
		logic [15:0] result;
		logic [3:0] cntHi;
		logic [3:0] cntLo;
	} state_type;

	state_type st;
	state_type next_st;
	logic sclRise;
	logic sclFall;
	logic startCond;
	logic stopCond;
	logic eocMode;
	logic latched;
	logic hiOver;
	logic loUnder;
	logic metHi;
	logic metLo;
	logic [3:0] need;
	logic [3:0] cntHiInc;
	logic [3:0] cntLoInc;
	logic [15:0] wrWord;

	// register read view; status bits overlay the stored configuration
	function automatic logic [15:0] readWord(input state_type s);
		logic [15:0] w;
		w = 16'h0000;
		if (s.ptr == PTR_RESULT) begin
			w = s.result;
		end else if (s.ptr == PTR_CONFIG) begin
			w = s.cfg;
			w[CFG_OVF] = 1'b0;
			w[CFG_CRF] = s.crf;
			w[CFG_FH] = s.flagHi;
			w[CFG_FL] = s.flagLo;
		end else if (s.ptr == PTR_LOWLIM) begin
			w = s.lowLim;
		end else if (s.ptr == PTR_HIGHLIM) begin
			w = s.highLim;
		end else if (s.ptr == PTR_MFR_ID) begin
			w = MFR_ID;
		end else if (s.ptr == PTR_DEV_ID) begin
			w = DEV_ID;
		end
		return w;
	endfunction

	// bus conditions from the previous and present pin samples
	assign sclRise = link.scl & ~st.sclPrev;
	assign sclFall = ~link.scl & st.sclPrev;
	assign startCond = link.scl & st.sclPrev & st.sdaPrev & ~link.sda;
	assign stopCond = link.scl & st.sclPrev & ~st.sdaPrev & link.sda;
	assign wrWord = {st.hiByte, st.shift};

	// mode decode and fault qualification on the incoming result
	assign eocMode = (st.lowLim[LIM_EOC_LSB +: 2] == EOC_CODE);
	assign latched = st.cfg[CFG_LATCH];
	assign need = {2'b00, st.cfg[CFG_FC_LSB +: 2]} + 4'h1;
	assign hiOver = convResult > st.highLim;
	assign loUnder = convResult < st.lowLim;
	assign cntHiInc = (st.cntHi == 4'hf) ? st.cntHi : st.cntHi + 4'h1;
	assign cntLoInc = (st.cntLo == 4'hf) ? st.cntLo : st.cntLo + 4'h1;
	assign metHi = hiOver && (cntHiInc >= need);
	assign metLo = loUnder && (cntLoInc >= need);

	// the whole next state: bus slave first, then status, conversion last
	always_comb begin
		logic cfgRead;
		logic cfgWrite;
		cfgRead = 1'b0;
		cfgWrite = 1'b0;
		next_st = st;
		next_st.sclPrev = link.scl;
		next_st.sdaPrev = link.sda;
		if (stopCond) begin
			next_st.phase = D_IDLE;
			next_st.sdaDrive = 1'b0;
		end else if (startCond) begin
			next_st.phase = D_RX;
			next_st.bitCnt = 4'h0;
			next_st.byteIdx = 2'b00;
			next_st.sdaDrive = 1'b0;
		end else begin
			case (st.phase)
				D_RX: begin
					if (sclRise && st.bitCnt < 4'h8) begin
						next_st.shift = {st.shift[6:0], link.sda};
						next_st.bitCnt = st.bitCnt + 4'h1;
					end else if (sclFall && st.bitCnt == 4'h8) begin
						next_st.bitCnt = 4'h0;
						if (st.byteIdx == 2'b00) begin
							if (st.shift[7:1] == SLAVE_ADDR) begin
								next_st.rw = st.shift[0];
								next_st.sdaDrive = 1'b1;
								next_st.phase = D_ACK;
								// the word is frozen here, so a read sees status before its own clear
								// a read uses the pointer from the last write
								next_st.txWord = readWord(st);
								cfgRead = st.shift[0] && (st.ptr == PTR_CONFIG);
							end else begin
								next_st.phase = D_IDLE; // not ours: no acknowledge
							end
						end else begin
							next_st.sdaDrive = 1'b1;
							next_st.phase = D_ACK;
							if (st.byteIdx == 2'b01) begin
								next_st.ptr = st.shift;
							end else if (st.byteIdx == 2'b10) begin
								next_st.hiByte = st.shift;
							end else if (st.ptr == PTR_CONFIG) begin
								next_st.cfg = wrWord;
								cfgWrite = 1'b1;
							end else if (st.ptr == PTR_LOWLIM) begin
								next_st.lowLim = wrWord;
							end else if (st.ptr == PTR_HIGHLIM) begin
								next_st.highLim = wrWord;
							end
						end
					end
				end
				D_ACK: begin
					if (sclFall && st.rw) begin
						next_st.sdaDrive = ~st.txWord[15]; // msb first
						next_st.txWord = {st.txWord[14:0], 1'b0};
						next_st.bitCnt = 4'h1;
						next_st.phase = D_TX;
					end else if (sclFall) begin
						next_st.sdaDrive = 1'b0;
						next_st.byteIdx = (st.byteIdx == 2'b11) ? st.byteIdx : st.byteIdx + 2'b01;
						next_st.phase = D_RX;
					end
				end
				D_TX: begin
					if (sclFall && st.bitCnt == 4'h8) begin
						next_st.sdaDrive = 1'b0; // leave the ack slot to the host
						next_st.phase = D_RACK;
					end else if (sclFall) begin
						next_st.sdaDrive = ~st.txWord[15];
						next_st.txWord = {st.txWord[14:0], 1'b0};
						next_st.bitCnt = st.bitCnt + 4'h1;
					end
				end
				D_RACK: begin
					if (sclRise && link.sda) begin
						next_st.phase = D_IDLE; // host refused more data
					end else if (sclFall) begin
						next_st.sdaDrive = ~st.txWord[15];
						next_st.txWord = {st.txWord[14:0], 1'b0};
						next_st.bitCnt = 4'h1;
						next_st.phase = D_TX;
					end
				end
				default: begin
					next_st.phase = D_IDLE;
				end
			endcase
		end
		// configuration read effects
		if (cfgRead) begin
			next_st.crf = 1'b0;
			if (latched) begin
				next_st.flagHi = 1'b0;
				next_st.flagLo = 1'b0;
				next_st.irqActive = 1'b0;
			end else if (eocMode) begin
				next_st.irqActive = 1'b0; // flags untouched
			end
		end
		// a shutdown write falls through with status untouched
		if (cfgWrite && wrWord[CFG_MODE_LSB +: 2] != MODE_SHUTDOWN) begin
			next_st.crf = 1'b0;
			if (eocMode && !latched) begin
				next_st.irqActive = 1'b0;
			end
		end
		// alert response only counts in the latched setting
		if (alertWon && latched) begin
			next_st.irqActive = 1'b0;
		end
		// conversion last so a same-cycle completion beats any clear
		if (convDone) begin
			next_st.result = convResult;
			next_st.cntHi = hiOver ? cntHiInc : 4'h0;
			next_st.cntLo = loUnder ? cntLoInc : 4'h0;
			next_st.crf = 1'b1;
			if (latched) begin
				if (metHi) begin
					next_st.flagHi = 1'b1;
					next_st.irqActive = 1'b1;
				end
				if (metLo) begin
					next_st.flagLo = 1'b1;
					next_st.irqActive = 1'b1;
				end
			end else if (metHi) begin
				next_st.flagHi = 1'b1;
				next_st.flagLo = 1'b0;
				next_st.irqActive = 1'b1;
			end else if (metLo) begin
				next_st.flagHi = 1'b0;
				next_st.flagLo = 1'b1;
				next_st.irqActive = 1'b0;
			end
			if (eocMode) begin
				next_st.irqActive = 1'b1;
			end
		end
		// pin pulled low when active with sense 0, or inactive with sense 1
		next_st.irqDrive = next_st.irqActive ^ next_st.cfg[CFG_SENSE];
		if (sys_rst) begin
			next_st = '0;
			next_st.phase = D_IDLE;
			next_st.sclPrev = 1'b1;
			next_st.sdaPrev = 1'b1;
			next_st.cfg = CFG_RESET;
			next_st.lowLim = LOWLIM_RESET;
			next_st.highLim = HIGHLIM_RESET;
			next_st.irqDrive = CFG_RESET[CFG_SENSE];
		end
	end

	// single state register
	always_ff @(posedge clk) begin
		st <= next_st;
	end

	// pins are open drain: only the enables move
	assign link.devSdaOut = 1'b0;
	assign link.devSdaOe = st.sdaDrive;
	assign link.devIrqOut = 1'b0;
	assign link.devIrqOe = st.irqDrive;
	assign opMode = st.cfg[CFG_MODE_LSB +: 2];
	assign resultWord = st.result;
endmodule

/* File: core/eoc_host_ctrl.sv */
// host end: AXI4-Lite controlled two-wire master for the light sensor
//
// The AXI4-Lite slave port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
module eoc_host_ctrl import eoc_link_pkg::*; #(
	parameter int QUARTER = QUARTER_CYCLES,
	parameter logic [6:0] SLAVE_ADDR = 7'h2a
) (
	// system
	input wire logic clk,
	input wire logic sys_rst,
	// two-wire link
	eoc_link_if.host link,
	// AXI4-Lite slave
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	if (QUARTER < 2 || QUARTER > 65535) begin : g_check
		$error("QUARTER must lie in 2..65535");
	end
	localparam logic [15:0] QTOP = 16'(QUARTER - 1);

	typedef enum logic [2:0] {
		OP_START = 3'b000,
		OP_WBYTE = 3'b001,
		OP_RBYTE = 3'b010,
		OP_STOP = 3'b011,
		OP_DONE = 3'b100
	} op_type;

	typedef struct packed {
		logic busy;
		logic rd;
		logic [3:0] step;
		logic [7:0] ptr;
		logic [15:0] data;
		logic [1:0] qCnt;
		logic [15:0] div;
		logic [3:0] bitIdx;
		logic nack;
		logic [15:0] rdData;
		logic sclOut;
		logic sdaDrive;
		logic [15:0] shadowCfg;
		logic shadowEoc;
		logic fixPending;
		logic awHeld;
		logic [3:0] awAddr;
		logic wHeld;
		logic [31:0] wData;
		logic [3:0] wStrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdataReg;
		logic [1:0] rresp;
	} state_type;

	state_type st;
	state_type next_st;

	// transaction script; a read always rewrites the pointer first
	function automatic op_type stepOp(input logic rd, input logic [3:0] step);
		op_type op;
		op = OP_DONE;
		if (step == 4'h0 || (rd && step == 4'h4)) begin
			op = OP_START;
		end else if (step <= 4'h2 || (!rd && step <= 4'h4) || (rd && step == 4'h5)) begin
			op = OP_WBYTE;
		end else if (rd && (step == 4'h6 || step == 4'h7)) begin
			op = OP_RBYTE;
		end else if ((rd && (step == 4'h3 || step == 4'h8)) || (!rd && step == 4'h5)) begin
			op = OP_STOP;
		end
		return op;
	endfunction

	// byte sent at a script step: address, pointer, then data high before low
	function automatic logic [7:0] txByte(input state_type s);
		logic [7:0] b;
		b = s.ptr;
		if (s.step == 4'h1) begin
			b = {SLAVE_ADDR, 1'b0};
		end else if (s.step == 4'h5) begin
			b = {SLAVE_ADDR, 1'b1};
		end else if (s.step == 4'h3) begin
			b = s.data[15:8];
		end else if (s.step == 4'h4) begin
			b = s.data[7:0];
		end
		return b;
	endfunction

	always_comb begin
		logic launch;
		logic launchRd;
		logic [7:0] launchPtr;
		logic [15:0] launchData;
		logic [3:0] wa;
		logic [3:0] ra;
		logic [7:0] curByte;
		logic [2:0] bsel;
		op_type op;
		launch = 1'b0;
		launchRd = 1'b0;
		launchPtr = 8'h00;
		launchData = 16'h0000;
		wa = {st.awAddr[3:2], 2'b00};
		ra = {s_axi_araddr[3:2], 2'b00};
		curByte = 8'h00;
		bsel = 3'h0;
		op = stepOp(st.rd, st.step);
		next_st = st;
		// write channel capture, address and data in either order
		if (s_axi_awvalid && !st.awHeld) begin
			next_st.awHeld = 1'b1;
			next_st.awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !st.wHeld) begin
			next_st.wHeld = 1'b1;
			next_st.wData = s_axi_wdata;
			next_st.wStrb = s_axi_wstrb;
		end
		if (st.bvalid && s_axi_bready) begin
			next_st.bvalid = 1'b0;
		end
		if (st.awHeld && st.wHeld && !st.bvalid) begin
			next_st.awHeld = 1'b0;
			next_st.wHeld = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp = AXI_OKAY;
			if (wa == REG_CTRL) begin
				// a start while busy is dropped rather than queued
				launch = st.wStrb[0] && st.wData[CTRL_GO] && !st.busy;
				launchRd = st.wData[CTRL_READ];
				launchPtr = st.wData[CTRL_PTR_LSB +: 8];
				launchData = st.data;
			end else if (wa == REG_WDATA) begin
				if (st.wStrb[0]) begin
					next_st.data[7:0] = st.wData[7:0];
				end
				if (st.wStrb[1]) begin
					next_st.data[15:8] = st.wData[15:8];
				end
			end else if (wa != REG_STATUS && wa != REG_RDATA) begin
				next_st.bresp = AXI_SLVERR;
			end
		end
		// read channel
		if (st.rvalid && s_axi_rready) begin
			next_st.rvalid = 1'b0;
		end
		if (s_axi_arvalid && !st.rvalid) begin
			next_st.rvalid = 1'b1;
			next_st.rresp = AXI_OKAY;
			next_st.rdataReg = 32'h0000_0000;
			if (ra == REG_CTRL) begin
				next_st.rdataReg[CTRL_PTR_LSB +: 8] = st.ptr;
				next_st.rdataReg[CTRL_READ] = st.rd;
			end else if (ra == REG_WDATA) begin
				next_st.rdataReg[15:0] = st.data;
			end else if (ra == REG_STATUS) begin
				next_st.rdataReg[STAT_BUSY] = st.busy;
				next_st.rdataReg[STAT_NACK] = st.nack;
				next_st.rdataReg[STAT_IRQ] = link.irqLine;
			end else if (ra == REG_RDATA) begin
				next_st.rdataReg[15:0] = st.rdData;
			end else begin
				next_st.rresp = AXI_SLVERR;
			end
		end
		// script sequencer: four quarters per bit or per start/stop
		if (st.busy && op == OP_DONE) begin
			next_st.busy = 1'b0;
			if (st.fixPending) begin
				// leaving end-of-conversion with latch set: rewrite latch to 0
				launch = 1'b1;
				launchRd = 1'b0;
				launchPtr = PTR_CONFIG;
				launchData = st.shadowCfg & ~(16'h0001 << CFG_LATCH);
				next_st.fixPending = 1'b0;
			end
		end else if (st.busy && st.div != QTOP) begin
			next_st.div = st.div + 16'h0001;
		end else if (st.busy) begin
			next_st.div = 16'h0000;
			next_st.qCnt = st.qCnt + 2'b01;
			if (st.qCnt == 2'b10 && op == OP_WBYTE && st.bitIdx == 4'h8) begin
				next_st.nack = link.sda;
			end else if (st.qCnt == 2'b10 && op == OP_RBYTE && st.bitIdx < 4'h8) begin
				next_st.rdData = {st.rdData[14:0], link.sda}; // high byte first
			end
			if (st.qCnt == 2'b11 && (op == OP_START || op == OP_STOP)) begin
				next_st.step = st.step + 4'h1;
			end else if (st.qCnt == 2'b11 && st.bitIdx != 4'h8) begin
				next_st.bitIdx = st.bitIdx + 4'h1;
			end else if (st.qCnt == 2'b11) begin
				next_st.bitIdx = 4'h0;
				next_st.step = st.step + 4'h1;
				if (op == OP_WBYTE && st.nack) begin
					next_st.step = st.rd ? 4'h8 : 4'h5; // refused byte: go to stop
				end
			end
		end
		if (launch) begin
			next_st.busy = 1'b1;
			next_st.rd = launchRd;
			next_st.ptr = launchPtr;
			next_st.data = launchData;
			next_st.step = 4'h0;
			next_st.qCnt = 2'b00;
			next_st.div = 16'h0000;
			next_st.bitIdx = 4'h0;
			next_st.nack = 1'b0;
			if (!launchRd && launchPtr == PTR_CONFIG) begin
				next_st.shadowCfg = launchData;
			end
			if (!launchRd && launchPtr == PTR_LOWLIM) begin
				next_st.shadowEoc = (launchData[LIM_EOC_LSB +: 2] == EOC_CODE);
				next_st.fixPending = st.shadowEoc && st.shadowCfg[CFG_LATCH]
					&& launchData[LIM_EOC_LSB +: 2] != EOC_CODE;
			end
		end
		// pin levels from the updated script position
		op = next_st.busy ? stepOp(next_st.rd, next_st.step) : OP_DONE;
		curByte = txByte(next_st);
		bsel = 3'h7 - next_st.bitIdx[2:0];
		case (op)
			OP_START: begin
				next_st.sclOut = !next_st.qCnt[1];
				next_st.sdaDrive = next_st.qCnt != 2'b00;
			end
			OP_STOP: begin
				next_st.sclOut = next_st.qCnt != 2'b00;
				next_st.sdaDrive = !next_st.qCnt[1];
			end
			OP_WBYTE: begin
				next_st.sclOut = next_st.qCnt[1];
				next_st.sdaDrive = next_st.bitIdx != 4'h8 && !curByte[bsel];
			end
			OP_RBYTE: begin
				next_st.sclOut = next_st.qCnt[1];
				// acknowledge the high byte, refuse the low one
				next_st.sdaDrive = next_st.bitIdx == 4'h8 && next_st.step == 4'h6;
			end
			default: begin
				next_st.sclOut = 1'b1;
				next_st.sdaDrive = 1'b0;
			end
		endcase
		if (sys_rst) begin
			next_st = '0;
			next_st.sclOut = 1'b1;
			next_st.shadowCfg = CFG_RESET;
			next_st.shadowEoc = (LOWLIM_RESET[LIM_EOC_LSB +: 2] == EOC_CODE);
		end
	end

	// single state register
	always_ff @(posedge clk) begin
		st <= next_st;
	end

	assign link.scl = st.sclOut;
	assign link.hostSdaOut = 1'b0;
	assign link.hostSdaOe = st.sdaDrive;
	assign s_axi_awready = !st.awHeld;
	assign s_axi_wready = !st.wHeld;
	assign s_axi_bvalid = st.bvalid;
	assign s_axi_bresp = st.bresp;
	assign s_axi_arready = !st.rvalid;
	assign s_axi_rvalid = st.rvalid;
	assign s_axi_rdata = st.rdataReg;
	assign s_axi_rresp = st.rresp;
endmodule

/* File: test/eoc_link_asserts.sv */
// concurrent checks on the two-wire link between host and sensor
`timescale 1ns/10ps
module eoc_link_asserts (
	// system
	input wire logic clk,
	input wire logic sys_rst,
	// link
	input wire logic scl,
	input wire logic hostSdaOe,
	input wire logic devSdaOe,
	input wire logic devIrqOe,
	input wire logic sda
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	// bit phases hold long enough for the sensor to sample
	a_scl_low_min: assert property ($fell(scl) |-> !scl [*4])
		else $error("scl low phase too short");
	a_scl_high_min: assert property ($rose(scl) |-> scl [*8])
		else $error("scl high phase too short");
	// only the host may frame a transfer while scl is high
	a_frame_by_host: assert property (scl && $past(scl) && $changed(sda) |-> $changed(hostSdaOe))
		else $error("sda moved under high scl without host");
	a_dev_hold_high: assert property (scl && $past(scl) |-> $stable(devSdaOe))
		else $error("sensor changed sda while scl high");
	a_dev_turn_low: assert property ($changed(devSdaOe) |-> !scl && !$past(scl))
		else $error("sensor changed sda too early");
	// host releases sda while scl is high whenever the sensor owns the bit
	a_no_contend: assert property (scl |-> !(hostSdaOe && devSdaOe))
		else $error("both ends pull sda");
	a_start_clocked: assert property (scl && $fell(sda) |-> ##[1:40] !scl)
		else $error("no clock after start");
	a_reset_quiet: assert property ($fell(sys_rst) |-> scl && !hostSdaOe && !devSdaOe && !devIrqOe)
		else $error("link not idle after reset");
endmodule

/* File: test/tb_eoc_interrupt_and_register_access.sv */
// self-checking bench: host controller and sensor joined over the link
`timescale 1ns/10ps
module tb_eoc_interrupt_and_register_access import eoc_link_pkg::*;;
	logic clk, sys_rst, convDone, alertWon;
	logic [15:0] convResult, resultWord, rv;
	logic [1:0] opMode, bresp, rresp;
	logic [3:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic awvalid, awready, wvalid, wready, bvalid, arvalid, arready, rvalid;
	int n_mismatch = 0;
	int n_compared = 0;
	int cyc = 0;
	eoc_link_if lk();
	eoc_host_ctrl #(.QUARTER(4)) eoc_host_ctrl_inst (.clk(clk), .sys_rst(sys_rst), .link(lk),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(1'b1));
	eoc_sensor_dev eoc_sensor_dev_inst (.clk(clk), .sys_rst(sys_rst), .link(lk),
		.convDone(convDone), .convResult(convResult), .alertWon(alertWon), .opMode(opMode),
		.resultWord(resultWord));
	eoc_link_asserts eoc_link_asserts_inst (.clk(clk), .sys_rst(sys_rst), .scl(lk.scl),
		.hostSdaOe(lk.hostSdaOe), .devSdaOe(lk.devSdaOe), .devIrqOe(lk.devIrqOe), .sda(lk.sda));
	// 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic print_verdict;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// cuts a hung link short, well above the length of the run
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			n_mismatch++;
			print_verdict();
		end
	end
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_compared++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	// bus handshakes are observed mid-cycle so the edge itself never races
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		logic ta, tw, tb;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		tb = 1'b0;
		while (!tb) begin
			@(negedge clk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb = bvalid;
			@(posedge clk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
		end
		// response code is held after bvalid drops, so it is stable here
		chk("bresp", {14'h0, AXI_OKAY}, {14'h0, bresp});
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		logic ta, tr;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		tr = 1'b0;
		while (!tr) begin
			@(negedge clk);
			ta = arvalid && arready;
			tr = rvalid;
			d = rdata;
			@(posedge clk);
			if (ta) arvalid <= 1'b0;
		end
		chk("rresp", {14'h0, AXI_OKAY}, {14'h0, rresp});
	endtask
	// start one link command and wait until the controller is idle
	task automatic go(input logic [7:0] p, input logic rdf);
		logic [31:0] s;
		wr(REG_CTRL, {16'h0, p, 6'h0, rdf, 1'b1});
		s = 32'h1;
		while (s[STAT_BUSY]) rd(REG_STATUS, s);
		chk("nack", 16'h0, {15'h0, s[STAT_NACK]});
	endtask
	task automatic lw(input logic [7:0] p, input logic [15:0] v);
		wr(REG_WDATA, {16'h0, v});
		go(p, 1'b0);
	endtask
	task automatic lr(input logic [7:0] p, output logic [15:0] v);
		logic [31:0] s;
		go(p, 1'b1);
		rd(REG_RDATA, s);
		v = s[15:0];
	endtask
	task automatic cfg(input logic [15:0] e);
		lr(PTR_CONFIG, rv);
		chk("cfg", e, rv);
	endtask
	task automatic pin(input logic e);
		chk("irq", {15'h0, e}, {15'h0, lk.irqLine});
	endtask
	task automatic conv(input logic [15:0] r);
		@(posedge clk);
		convDone <= 1'b1;
		convResult <= r;
		@(posedge clk);
		convDone <= 1'b0;
		repeat (3) @(posedge clk);
		chk("result", r, resultWord);
	endtask
	task automatic alert;
		@(posedge clk);
		alertWon <= 1'b1;
		@(posedge clk);
		alertWon <= 1'b0;
		repeat (3) @(posedge clk);
	endtask
	// latched window with end-of-conversion, fault count of two
	task automatic s_latched;
		lw(PTR_HIGHLIM, 16'hc800);
		lw(PTR_LOWLIM, 16'hc000);
		lr(PTR_LOWLIM, rv);
		chk("low", 16'hc000, rv);
		lw(PTR_CONFIG, 16'h0411);
		chk("mode", 16'h0002, {14'h0, opMode});
		conv(16'h1000);
		pin(1'b0);
		cfg(16'h0491);
		pin(1'b1);
		conv(16'h1000);
		conv(16'h1000);
		cfg(16'h04b1);
		cfg(16'h0411);
		conv(16'hd05a);
		conv(16'hd05a);
		pin(1'b0);
		lr(PTR_RESULT, rv);
		chk("res", 16'hd05a, rv);
		alert();
		pin(1'b1);
		cfg(16'h04d1);
	endtask
	// shutdown and running configuration writes
	task automatic s_modewr;
		conv(16'h1000);
		lw(PTR_CONFIG, 16'h0011);
		pin(1'b0);
		cfg(16'h0091);
		lw(PTR_CONFIG, 16'h0411);
		conv(16'h1000);
		conv(16'h1000);
		lw(PTR_CONFIG, 16'h0411);
		pin(1'b0);
		cfg(16'h0431);
	endtask
	// transparent comparison with end-of-conversion
	task automatic s_transp;
		lw(PTR_CONFIG, 16'h0401);
		conv(16'hd05a);
		conv(16'hd05a);
		cfg(16'h04c1);
		pin(1'b1);
		cfg(16'h0441);
		conv(16'h1000);
		conv(16'h1000);
		alert();
		pin(1'b0);
		lw(PTR_CONFIG, 16'h0401);
		pin(1'b1);
		cfg(16'h0421);
	endtask
	// inverted sense, then leaving end-of-conversion
	task automatic s_sense_leave;
		lw(PTR_CONFIG, 16'h0419);
		pin(1'b0);
		conv(16'hc400);
		pin(1'b1);
		lr(PTR_CONFIG, rv);
		lw(PTR_LOWLIM, 16'h0000);
		conv(16'hc400);
		pin(1'b0);
		lr(PTR_CONFIG, rv);
		chk("latch", 16'h0000, {15'h0, rv[CFG_LATCH]});
	endtask
	// reset, then the scenarios in turn
	initial begin
		sys_rst = 1'b1;
		convDone = 1'b0;
		alertWon = 1'b0;
		convResult = 16'h0000;
		awaddr = 4'h0;
		araddr = 4'h0;
		wdata = 32'h0;
		awvalid = 1'b0;
		wvalid = 1'b0;
		arvalid = 1'b0;
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		pin(1'b1);
		s_latched();
		s_modewr();
		s_transp();
		s_sense_leave();
		print_verdict();
	end
endmodule
